// *** core/scr_system_config.sv ***
`timescale 1ns/1ps

module scr_system_config
  import scr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // Serial port
  input  wire logic        spi_sck_i,
  input  wire logic        spi_csn_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_n_o,
  output logic             spi_count_error_o,
  // Feedback and mode events
  input  wire logic [11:0] gp_feedback0_i,
  input  wire logic        restart_failsafe_entry_i,
  // Reset pin, open drain
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_n_o,
  // Configuration outputs
  output logic             ground_offset_threshold_sel_o,
  output logic             reset_stretch_select_o,
  output scr_aux_mode_t    aux_supply_mode_o,
  output logic             wake_sampling_select_o,
  // Current monitor
  input  wire logic        standby_i,
  input  wire logic        watchdog_disabled_i,
  input  wire logic        main_current_rise_i,
  output logic             watchdog_reactivate_o,
  // Wake input
  input  wire logic        wake_pin_i,
  input  wire logic        wake_status_clear_i,
  output logic             wake_status_flag_a_o,
  output logic             wake_level_status_o,
  // Inhibit output
  output logic             inhibit_limp_output_o,
  output logic             inhibit_limp_output_oe_n_o
);

  logic sck;
  logic csn;
  logic mosi;
  logic rst_pin;
  logic wake_pin;

  scr_pin_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .pin_i (spi_sck_i), .level_o (sck));
  scr_pin_sync #(.RESET_VAL(1'b1)) u_sync_csn (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .pin_i (spi_csn_i), .level_o (csn));
  scr_pin_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .pin_i (spi_mosi_i), .level_o (mosi));
  scr_pin_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .pin_i (rst_pin_i), .level_o (rst_pin));
  scr_pin_sync #(.RESET_VAL(1'b1)) u_sync_wake (
    .core_clk_i (core_clk_i), .reset_i (reset_i), .pin_i (wake_pin_i), .level_o (wake_pin));

  // ****************************************************************
  // Serial frame: sample on sck rise, shift out on sck fall
  // ****************************************************************
  logic        sck_q;
  logic        csn_q;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic [15:0] tx_word;
  logic [15:0] next_tx_word;
  logic        miso;
  logic        next_miso;
  logic        cnt_err;
  logic        next_cnt_err;
  logic        commit;
  scr_cfg_t    cfg;
  scr_cfg_t    next_cfg;

  logic        sck_rise;
  logic        sck_fall;
  logic        csn_fall;
  logic        csn_rise;
  logic [11:0] readback_cfg;

  assign sck_rise     = sck && !sck_q && !csn;
  assign sck_fall     = !sck && sck_q && !csn;
  assign csn_fall     = !csn && csn_q;
  assign csn_rise     = csn && !csn_q;
  assign readback_cfg = cfg & CFG_WRITE_MASK;

  always_comb begin
    next_shift   = shift;
    next_cnt     = cnt;
    next_tx_word = tx_word;
    next_miso    = miso;
    next_cnt_err = 1'b0;
    commit       = 1'b0;
    if (csn_fall) begin
      next_cnt     = 5'h00;
      next_tx_word = {READBACK_TOP, 12'h000};
      next_miso    = READBACK_TOP[3];
    end else if (sck_rise) begin
      next_shift = {shift[14:0], mosi};
      if (cnt != FRAME_OVER) begin
        next_cnt = cnt + 5'h01;
      end
      // Source is known once address and read-select are in
      if (cnt + 5'h01 == SELECT_POINT) begin
        if (next_shift[2:1] != ADDR_SYSCFG) begin
          next_tx_word = {READBACK_TOP, 12'h000};
        end else if (next_shift[0]) begin
          next_tx_word = {READBACK_TOP, gp_feedback0_i};
        end else begin
          next_tx_word = {READBACK_TOP, readback_cfg};
        end
      end
    end else if (sck_fall && cnt < FRAME_LEN) begin
      next_miso = tx_word[4'(FRAME_BITS - 1) - cnt[3:0]];
    end else if (csn_rise) begin
      if (cnt != FRAME_LEN) begin
        next_cnt_err = 1'b1;
      end else if (shift[ADDR_HI:ADDR_LO] == ADDR_SYSCFG && !shift[READ_ONLY_BIT]) begin
        commit = 1'b1;
      end
    end
  end

  // Hardware set wins over a frame written in the same cycle
  always_comb begin
    next_cfg = cfg;
    if (commit) begin
      next_cfg = scr_cfg_t'(shift[CFG_MSB:0] & CFG_WRITE_MASK);
    end
    if (restart_failsafe_entry_i) begin
      next_cfg.reset_stretch_select = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sck_q   <= 1'b0;
      csn_q   <= 1'b1;
      shift   <= 16'h0000;
      cnt     <= 5'h00;
      tx_word <= 16'h0000;
      miso    <= 1'b0;
      cnt_err <= 1'b0;
      cfg     <= scr_cfg_t'(CFG_RESET);
    end else begin
      sck_q   <= sck;
      csn_q   <= csn;
      shift   <= next_shift;
      cnt     <= next_cnt;
      tx_word <= next_tx_word;
      miso    <= next_miso;
      cnt_err <= next_cnt_err;
      cfg     <= next_cfg;
    end
  end

  assign spi_miso_o                    = miso;
  assign spi_miso_oe_n_o               = csn;
  assign spi_count_error_o             = cnt_err;
  assign ground_offset_threshold_sel_o = cfg.ground_offset_threshold_sel;
  assign reset_stretch_select_o        = cfg.reset_stretch_select;
  assign aux_supply_mode_o             = cfg.aux_supply_mode;
  assign wake_sampling_select_o        = cfg.wake_sampling_select;

  // ****************************************************************
  // Current monitor and reset stretch
  // ****************************************************************
  logic           current_reset;
  logic           wd_react;
  logic           next_wd_react;
  scr_rst_state_t rst_state;
  scr_rst_state_t next_rst_state;
  logic [11:0]    rst_cnt;
  logic [11:0]    next_rst_cnt;
  logic           rst_start;

  assign current_reset = main_current_rise_i && standby_i && cfg.main_current_monitor_sel
                         && watchdog_disabled_i;
  assign next_wd_react = main_current_rise_i && standby_i && !current_reset;
  assign rst_start     = !rst_pin || current_reset;

  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt   = rst_cnt;
    case (rst_state)
      SCR_RST_IDLE: begin
        if (rst_start) begin
          next_rst_state = SCR_RST_STRETCH;
          next_rst_cnt   = cfg.reset_stretch_select ? RST_LONG_CNT - 12'h001
                                                    : RST_SHORT_CNT - 12'h001;
        end
      end
      SCR_RST_STRETCH: begin
        if (rst_cnt == 12'h000) begin
          next_rst_state = SCR_RST_BLANK;
          next_rst_cnt   = RST_BLANK_CNT;
        end else begin
          next_rst_cnt = rst_cnt - 12'h001;
        end
      end
      // Our own low drive echoes back through the synchroniser; skip it
      SCR_RST_BLANK: begin
        if (rst_cnt == 12'h000) begin
          next_rst_state = SCR_RST_IDLE;
        end else begin
          next_rst_cnt = rst_cnt - 12'h001;
        end
      end
      default: begin
        next_rst_state = SCR_RST_IDLE;
        next_rst_cnt   = 12'h000;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rst_state <= SCR_RST_IDLE;
      rst_cnt   <= 12'h000;
      wd_react  <= 1'b0;
    end else begin
      rst_state <= next_rst_state;
      rst_cnt   <= next_rst_cnt;
      wd_react  <= next_wd_react;
    end
  end

  assign rst_pin_o             = 1'b0;
  assign rst_pin_oe_n_o        = rst_state != SCR_RST_STRETCH;
  assign watchdog_reactivate_o = wd_react;

  // ****************************************************************
  // Wake input and inhibit output
  // ****************************************************************
  logic [7:0] wake_tick;
  logic [7:0] next_wake_tick;
  logic       wake_level;
  logic       next_wake_level;
  logic       wake_flag;
  logic       next_wake_flag;
  logic       wake_sample;
  logic       inh_out;
  logic       inh_oe_n;

  assign wake_sample = !cfg.wake_sampling_select || wake_tick == 8'h00;

  always_comb begin
    next_wake_tick  = (wake_tick == 8'h00) ? WAKE_SAMPLE_CNT - 8'h01 : wake_tick - 8'h01;
    next_wake_level = wake_level;
    next_wake_flag  = wake_flag;
    if (wake_status_clear_i) begin
      next_wake_flag = 1'b0;
    end
    if (cfg.wake_enable && wake_sample) begin
      next_wake_level = wake_pin;
      if (wake_level && !wake_pin) begin
        next_wake_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_tick  <= 8'h00;
      wake_level <= 1'b1;
      wake_flag  <= 1'b0;
      inh_out    <= 1'b0;
      inh_oe_n   <= 1'b1;
    end else begin
      wake_tick  <= next_wake_tick;
      wake_level <= next_wake_level;
      wake_flag  <= next_wake_flag;
      inh_out    <= cfg.inhibit_output_level;
      inh_oe_n   <= !cfg.inhibit_output_enable;
    end
  end

  assign wake_level_status_o        = wake_level;
  assign wake_status_flag_a_o       = wake_flag;
  assign inhibit_limp_output_o      = inh_out;
  assign inhibit_limp_output_oe_n_o = inh_oe_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  frame_store_a: assert property (commit && !restart_failsafe_entry_i |=>
    cfg == scr_cfg_t'($past(shift[CFG_MSB:0]) & CFG_WRITE_MASK))
    else $error("stored configuration differs from frame");
  hold_config_a: assert property (!commit && !restart_failsafe_entry_i |=> $stable(cfg))
    else $error("configuration changed without a writing frame");
  read_only_a: assert property (csn_rise && shift[READ_ONLY_BIT] && !restart_failsafe_entry_i
    |=> $stable(cfg)) else $error("read-only frame changed configuration");
  count_ignore_a: assert property (csn_rise && cnt != FRAME_LEN |=> $stable(cfg[CFG_MSB:0] & 12'h2ff)
    && spi_count_error_o) else $error("bad clock count frame not ignored");
  readback_src_a: assert property (sck_rise && cnt == 5'h02 && next_shift[2:0] == 3'h5
    |=> tx_word[11:0] == $past(gp_feedback0_i)) else $error("wrong readback source");
  stretch_force_a: assert property (restart_failsafe_entry_i |=> reset_stretch_select_o)
    else $error("stretch bit not forced");
  stretch_len_a: assert property (rst_state == SCR_RST_IDLE && rst_start && !cfg.reset_stretch_select
    |=> !rst_pin_oe_n_o [*8] ##0 rst_cnt == RST_SHORT_CNT - 12'h008) else $error("short stretch wrong");
  current_mon_a: assert property (main_current_rise_i && standby_i && !cfg.main_current_monitor_sel
    |=> watchdog_reactivate_o) else $error("watchdog not reactivated");
  wake_frozen_a: assert property (!cfg.wake_enable && !wake_status_clear_i
    |=> $stable(wake_level_status_o) && $stable(wake_status_flag_a_o)) else $error("wake status moved");
  inhibit_drive_a: assert property (##1 inhibit_limp_output_oe_n_o == !$past(cfg.inhibit_output_enable)
    && inhibit_limp_output_o == $past(cfg.inhibit_output_level)) else $error("inhibit output wrong");

endmodule

// *** shared/scr_pkg.sv ***
package scr_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int          FRAME_BITS      = 16;
  localparam logic [4:0]  FRAME_LEN       = 5'h10;
  localparam logic [4:0]  FRAME_OVER      = 5'h11;
  localparam logic [4:0]  SELECT_POINT    = 5'h03;
  localparam logic [1:0]  ADDR_SYSCFG     = 2'h2;
  localparam int          ADDR_HI         = 15;
  localparam int          ADDR_LO         = 14;
  localparam int          RRS_BIT         = 13;
  localparam int          READ_ONLY_BIT   = 12;
  localparam int          CFG_MSB         = 11;
  localparam logic [3:0]  READBACK_TOP    = 4'h0;

  // Writable configuration bits; reserved 11, 10 and 5 are kept clear
  localparam logic [11:0] CFG_WRITE_MASK  = 12'h3df;
  localparam logic [11:0] CFG_RESET       = 12'h000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          RST_SHORT_NS    = 1000;
  localparam int          RST_LONG_NS     = 20000;
  localparam int          WAKE_SAMPLE_NS  = 1000;
  localparam logic [11:0] RST_SHORT_CNT   = 12'((RST_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RST_LONG_CNT    = 12'((RST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] RST_BLANK_CNT   = 12'h004;
  localparam logic [7:0]  WAKE_SAMPLE_CNT = 8'((WAKE_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SCR_AUX_OFF    = 2'h0,
    SCR_AUX_ON     = 2'h1,
    SCR_AUX_CYC_SH = 2'h2,
    SCR_AUX_CYC_LG = 2'h3
  } scr_aux_mode_t;

  typedef struct packed {
    logic [1:0]    rsvd_hi;
    logic          ground_offset_threshold_sel;
    logic          reset_stretch_select;
    scr_aux_mode_t aux_supply_mode;
    logic          rsvd_mid;
    logic          main_current_monitor_sel;
    logic          wake_enable;
    logic          wake_sampling_select;
    logic          inhibit_output_enable;
    logic          inhibit_output_level;
  } scr_cfg_t;

  typedef enum logic [1:0] {
    SCR_RST_IDLE    = 2'h0,
    SCR_RST_STRETCH = 2'h1,
    SCR_RST_BLANK   = 2'h2
  } scr_rst_state_t;

endpackage

// *** core/scr_pin_sync.sv ***
`timescale 1ns/1ps

module scr_pin_sync
  import scr_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // Pin
  input  wire logic pin_i,
  output logic      level_o
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;
  logic next_level;

  // ****************************************************************
  // Filter: a change counts once stages two and three agree
  // ****************************************************************
  always_comb begin
    next_level = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level  <= RESET_VAL;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign level_o = level;

endmodule

// *** dv/scr_host_model.sv ***
`timescale 1ns/1ps

module scr_host_model
  import scr_pkg::*;
(
  // Clock
  input  wire logic core_clk_i,
  // Serial port
  input  wire logic spi_miso_i,
  output logic      spi_sck_o,
  output logic      spi_csn_o,
  output logic      spi_mosi_o
);
  initial begin
    spi_sck_o  = 1'b0;
    spi_csn_o  = 1'b1;
    spi_mosi_o = 1'b1;
  end

  // ****************************************************************
  // Frame master, mode 0, half is the sck phase in core clocks
  // ****************************************************************
  task automatic xfer(input logic [15:0] word, input int nclk, input int half, output logic [15:0] rd);
    logic [15:0] w;
    w  = word & 16'hf3df;
    rd = 16'h0000;
    @(posedge core_clk_i);
    spi_csn_o <= 1'b0;
    for (int k = 0; k < nclk; k++) begin
      spi_mosi_o <= w[15 - (k % FRAME_BITS)];
      repeat (half) @(posedge core_clk_i);
      if (k < FRAME_BITS) rd[15 - k] = spi_miso_i;
      spi_sck_o <= 1'b1;
      repeat (half) @(posedge core_clk_i);
      spi_sck_o <= 1'b0;
    end
    repeat (half) @(posedge core_clk_i);
    spi_csn_o  <= 1'b1;
    // Released data line must not keep looking valid
    spi_mosi_o <= ~spi_mosi_o;
    repeat (12) @(posedge core_clk_i);
  endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps

module tb_top
  import scr_pkg::*;
;
  logic          clk = 1'b0, rst = 1'b1, entry = 1'b0, rst_ext_n = 1'b1, stby = 1'b0, wd_off = 1'b0;
  logic          rise = 1'b0, wake = 1'b1, wclr = 1'b0;
  logic [11:0]   gp = 12'h000, st = 12'h000, old, nxt;
  logic          sck, csn, mosi, miso, moe_n, cerr, rst_wire, rst_drv, rst_oe_n;
  logic          gsel, rsel, wsel, react, wflag, wlevel, inh, inh_oe_n;
  scr_aux_mode_t aux;
  logic [15:0]   rd, ech;
  int            n_errors = 0, total_checks = 0, n_cerr = 0, n_react = 0, hp = 8;

  // Reset pin has a pull-up; the device only pulls it low
  assign rst_wire = rst_ext_n & (rst_oe_n | rst_drv);

  initial forever #5 clk = ~clk;

  scr_system_config scr_system_config_inst (
    .core_clk_i(clk), .reset_i(rst), .spi_sck_i(sck), .spi_csn_i(csn), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_n_o(moe_n), .spi_count_error_o(cerr), .gp_feedback0_i(gp),
    .restart_failsafe_entry_i(entry), .rst_pin_i(rst_wire), .rst_pin_o(rst_drv), .rst_pin_oe_n_o(rst_oe_n),
    .ground_offset_threshold_sel_o(gsel), .reset_stretch_select_o(rsel), .aux_supply_mode_o(aux),
    .wake_sampling_select_o(wsel), .standby_i(stby), .watchdog_disabled_i(wd_off),
    .main_current_rise_i(rise), .watchdog_reactivate_o(react), .wake_pin_i(wake),
    .wake_status_clear_i(wclr), .wake_status_flag_a_o(wflag), .wake_level_status_o(wlevel),
    .inhibit_limp_output_o(inh), .inhibit_limp_output_oe_n_o(inh_oe_n));

  scr_host_model scr_host_model_inst (
    .core_clk_i(clk), .spi_miso_i(miso), .spi_sck_o(sck), .spi_csn_o(csn), .spi_mosi_o(mosi));

  always @(posedge clk) begin
    if (cerr === 1'b1) n_cerr++;
    if (react === 1'b1) n_react++;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic end_sim();
    $display("Checks: %0d mismatches: %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] exp_rd(input logic [1:0] a, input logic readback_source_select, input logic [11:0] c);
    if (a != ADDR_SYSCFG) return 16'h0000;
    return {4'h0, readback_source_select ? gp : (c & CFG_WRITE_MASK)};
  endfunction

  task automatic frame(input logic [1:0] a, input logic readback_source_select, input logic ro, input logic [11:0] c, input int n);
    scr_host_model_inst.xfer({a, readback_source_select, ro, c}, n, hp, rd);
  endtask

  task automatic chk_cfg(input logic [11:0] c);
    chk("cfg_bits", {11'h0, c[9:6], c[2]}, {11'h0, gsel, rsel, aux, wsel});
    chk("inhibit", {14'h0, ~c[1], c[1] & c[0]}, {14'h0, inh_oe_n, inh & ~inh_oe_n});
    frame(ADDR_SYSCFG, 1'b0, 1'b1, ~c, 16);
    chk("readback", exp_rd(ADDR_SYSCFG, 1'b0, c), rd);
    chk("cfg_hold", {11'h0, c[9:6], c[2]}, {11'h0, gsel, rsel, aux, wsel});
  endtask

  task automatic wr(input logic [11:0] c);
    frame(ADDR_SYSCFG, 1'b0, 1'b0, c, 16);
    ech = rd;
    st  = c & CFG_WRITE_MASK;
    chk_cfg(st);
  endtask

  task automatic pulse(input bit sel);
    @(posedge clk);
    if (sel) rise <= 1'b1;
    else entry <= 1'b1;
    @(posedge clk);
    rise  <= 1'b0;
    entry <= 1'b0;
  endtask

  task automatic ext_low();
    @(posedge clk);
    rst_ext_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_ext_n <= 1'b1;
  endtask

  // Counts the cycles the reset pin is pulled low by the device
  task automatic stretch(input logic [15:0] exp);
    int n;
    n = 0;
    while (rst_oe_n !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_errors++;
        $display("[FAIL] stretch_start expected low seen timeout");
        end_sim();
      end
      @(posedge clk);
    end
    n = 0;
    while (rst_oe_n === 1'b0 && n < 3000) begin
      n++;
      @(posedge clk);
    end
    chk("stretch_len", exp, 16'(n));
    repeat (12) @(posedge clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h8c55be37));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("idle_pins", 16'h0003, {13'h0, wflag, wlevel, moe_n});
    chk_cfg(12'h000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      hp  = (i % 2 == 1) ? 20 : 8;
      gp  <= 12'($urandom());
      nxt = 12'($urandom());
      nxt[7:6] = i[1:0];
      nxt[1]   = i[2];
      old = st;
      wr(nxt);
      chk("write_echo", exp_rd(ADDR_SYSCFG, 1'b0, old), ech);
      frame(ADDR_SYSCFG, 1'b1, 1'b1, ~st, 16);
      chk("gp_read", exp_rd(ADDR_SYSCFG, 1'b1, st), rd);
    end
    hp = 8;
    $display("test random writes done");
    for (int a = 0; a < 4; a++) begin
      if (a == 2) continue;
      frame(2'(a), 1'b0, 1'b0, ~st, 16);
      chk("other_addr", 16'h0000, rd);
      chk_cfg(st);
    end
    $display("test addresses done");
    for (int i = 0; i < 2; i++) begin
      frame(ADDR_SYSCFG, 1'b0, 1'b0, ~st, 15 + 2 * i);
      chk("count_err", 16'(i + 1), 16'(n_cerr));
      chk_cfg(st);
    end
    $display("test clock count done");
    wr(st & 12'h2cf);
    pulse(1'b0);
    repeat (3) @(posedge clk);
    st[8] = 1'b1;
    chk_cfg(st);
    ext_low();
    stretch(16'(RST_LONG_CNT));
    wr(st & 12'h2cf);
    ext_low();
    stretch(16'(RST_SHORT_CNT));
    $display("test reset stretch done");
    wr(st | 12'h010);
    stby   <= 1'b1;
    wd_off <= 1'b1;
    pulse(1'b1);
    stretch(16'(RST_SHORT_CNT));
    chk("no_revive", 16'h0000, 16'(n_react));
    wr(st & 12'h2ef);
    pulse(1'b1);
    repeat (4) @(posedge clk);
    chk("revive", 16'h0003, {15'(n_react), rst_oe_n});
    $display("test current monitor done");
    wr((st & 12'h2f3) | 12'h008);
    wake <= 1'b0;
    repeat (10) @(posedge clk);
    chk("wake_cont", 16'h0002, {14'h0, wflag, wlevel});
    wake <= 1'b1;
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    repeat (10) @(posedge clk);
    chk("wake_clear", 16'h0001, {14'h0, wflag, wlevel});
    wr(st & 12'h2f7);
    wake <= 1'b0;
    repeat (20) @(posedge clk);
    chk("wake_off", 16'h0001, {14'h0, wflag, wlevel});
    wake <= 1'b1;
    wr(st | 12'h00c);
    wake <= 1'b0;
    repeat (130) @(posedge clk);
    chk("wake_cyclic", 16'h0002, {14'h0, wflag, wlevel});
    // A drop just after a sample must wait for the next tick, unlike continuous mode
    wake <= 1'b1;
    for (int n = 0; n < 120 && wlevel !== 1'b1; n++) @(posedge clk);
    wake <= 1'b0;
    repeat (20) @(posedge clk);
    chk("wake_hold", 16'h0003, {14'h0, wflag, wlevel});
    $display("test wake done");
    end_sim();
  end
endmodule
